// *** rtl/lwsp_pkg.sv ***
// constants and types shared by the late write synchronous sram port
// assumes a single rising edge clock domain and no bus between blocks
package lwsp_pkg;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DATA_W = 36;
  localparam int ADDR_W = 18;
  localparam int SEED_W = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 36;
  localparam int SLEEP_SYNC = 2;
  localparam logic [35:0] DOUT_RST = 36'h000000000;
  localparam logic [1:0] SEED_RST = 2'h0;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [1:0] CNT_STEP = 2'h1;

  typedef enum logic [1:0] {
    LWSP_IDLE,
    LWSP_READ,
    LWSP_WRITE
  } lwsp_op_e;
endpackage

// *** rtl/lwsp_fifo.sv ***
// small first in first out buffer with valid and ready on both sides
// assumes synchronous push and pop on the same clock
`timescale 1ns/1ps
module lwsp_fifo #(
  parameter int WIDTH = lwsp_pkg::FIFO_WIDTH,
  parameter int DEPTH = lwsp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] DEPTH_C = (PTR_W+1)'(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0] count_q;
  wire push;
  wire pop;

  assign in_ready = (count_q != DEPTH_C);
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // wrapping pointers
  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(DEPTH - 1)) begin
      bump = '0;
    end else begin
      bump = p + PTR_W'(1);
    end
  endfunction

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= bump(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= bump(rd_ptr_q);
      end
      if (push & ~pop) begin
        count_q <= count_q + (PTR_W+1)'(1);
      end else if (pop & ~push) begin
        count_q <= count_q - (PTR_W+1)'(1);
      end
    end
  end
endmodule

// *** rtl/lwsp_burst.sv ***
// two bit burst address generator, linear or interleaved order
// assumes load and step are only seen on clock edges the port accepts
`timescale 1ns/1ps
module lwsp_burst (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic step_en,
  input wire logic load,
  input wire logic linear_order_n,
  input wire logic [1:0] seed,
  // address low bits used in this cycle
  output logic [1:0] low_addr
);
  logic [1:0] seed_q;
  logic [1:0] cnt_q;
  wire [1:0] cnt_next;
  wire [1:0] step_addr;

  assign cnt_next = cnt_q + lwsp_pkg::CNT_STEP;
  assign step_addr = linear_order_n ? (seed_q ^ cnt_next)
                                    : (seed_q + cnt_next);
  assign low_addr = load ? seed : step_addr;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seed_q <= lwsp_pkg::SEED_RST;
      cnt_q <= lwsp_pkg::CNT_RST;
    end else if (step_en) begin
      if (load) begin
        seed_q <= seed;
        cnt_q <= lwsp_pkg::CNT_RST;
      end else begin
        cnt_q <= cnt_next;
      end
    end
  end
endmodule

// *** rtl/lwsp_top.sv ***
// synchronous late write sram port with memory core and output stage
// assumes inputs synchronous to ref_clk except sleep and output enable
//
// Contract
// - inputs sampled on rising clock edge only
// - output enable low-active, asynchronous driver kill
// - pipelined read data released next edge
// - mode pin low means flow-through
// - clock gate high freezes all state but the sleep synchroniser
// - selected only when all three selects active
// - read begins on selected load with write high
// - write only lanes whose strobes are low
// - pipelined write data taken third edge
// - flow-through read data one cycle earlier
// - flow-through write data taken second edge
// - writes self-timed from clock edge
// - low address bits seed burst counter
// - sleep input asynchronous, active high
// - read and write back to back allowed
// - advance high steps counter, same operation
// - counter wraps after four, linear or xor
// - clock gate holds bus state during stall
// - sleep after two cycles, outputs released
`timescale 1ns/1ps
module lwsp_top #(
  parameter int ADDR_W = lwsp_pkg::ADDR_W,
  parameter int FIFO_DEPTH = lwsp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // address
  input wire logic [ADDR_W-3:0] addr_hi,
  input wire logic [1:0] burst_seed_addr,
  // access control
  input wire logic advance_load,
  input wire logic write_select_n,
  input wire logic select_first_n,
  input wire logic select_second,
  input wire logic select_third_n,
  input wire logic clk_gate_n,
  input wire logic output_enable_n,
  // lane write strobes
  input wire logic lane_a_strobe_n,
  input wire logic lane_b_strobe_n,
  input wire logic lane_c_strobe_n,
  input wire logic lane_d_strobe_n,
  // mode pins
  input wire logic flow_mode_n,
  input wire logic linear_order_n,
  input wire logic sleep_request,
  // lane a data pins
  input wire logic [8:0] lane_a_io_i,
  output logic [8:0] lane_a_io_o,
  output logic [8:0] lane_a_io_oe,
  // lane b data pins
  input wire logic [8:0] lane_b_io_i,
  output logic [8:0] lane_b_io_o,
  output logic [8:0] lane_b_io_oe,
  // lane c data pins
  input wire logic [8:0] lane_c_io_i,
  output logic [8:0] lane_c_io_o,
  output logic [8:0] lane_c_io_oe,
  // lane d data pins
  input wire logic [8:0] lane_d_io_i,
  output logic [8:0] lane_d_io_o,
  output logic [8:0] lane_d_io_oe,
  // status
  output logic sleep_active
);
  localparam int LW = lwsp_pkg::LANE_W;
  localparam int NL = lwsp_pkg::LANES;
  localparam int DW = lwsp_pkg::DATA_W;
  localparam int DEPTH = 1 << ADDR_W;

  // memory core
  logic [DW-1:0] mem [0:DEPTH-1];

  // sleep synchroniser
  logic sleep_s1_q;
  logic sleep_s2_q;

  // command pipeline
  lwsp_pkg::lwsp_op_e last_op_q;
  lwsp_pkg::lwsp_op_e s1_op_q;
  lwsp_pkg::lwsp_op_e s2_op_q;
  logic [ADDR_W-1:0] s1_addr_q;
  logic [ADDR_W-1:0] s2_addr_q;
  logic [NL-1:0] s1_lanes_q;
  logic [NL-1:0] s2_lanes_q;

  // output stage
  logic [DW-1:0] dout_q;
  logic doe_q;

  // decode
  wire active;
  wire selected;
  wire load;
  wire flow;
  wire read_go;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [DW-1:0] fifo_out_data;
  wire [DW-1:0] din;
  wire [DW-1:0] rd_data;
  wire [1:0] low_addr;
  wire [ADDR_W-1:0] eff_addr;
  wire [NL-1:0] lanes_now;
  wire wb_write;
  wire [ADDR_W-1:0] wb_addr;
  wire [NL-1:0] wb_lanes;
  wire drive;
  lwsp_pkg::lwsp_op_e op_now;
  lwsp_pkg::lwsp_op_e wr_keep;

  assign active = ~clk_gate_n & ~sleep_s2_q;
  assign selected = ~select_first_n & select_second & ~select_third_n;
  assign load = ~advance_load;
  assign flow = ~flow_mode_n;
  assign op_now = load ? (selected ? (write_select_n ? lwsp_pkg::LWSP_READ
                                                     : lwsp_pkg::LWSP_WRITE)
                                   : lwsp_pkg::LWSP_IDLE)
                       : last_op_q;
  assign lanes_now = ~{lane_d_strobe_n, lane_c_strobe_n,
                       lane_b_strobe_n, lane_a_strobe_n};
  assign din = {lane_d_io_i, lane_c_io_i, lane_b_io_i, lane_a_io_i};
  assign eff_addr = {addr_hi, low_addr};
  assign rd_data = mem[eff_addr];
  assign read_go = active & (op_now == lwsp_pkg::LWSP_READ) &
                   (flow | fifo_in_ready);
  assign wr_keep = (op_now == lwsp_pkg::LWSP_WRITE) ? lwsp_pkg::LWSP_WRITE
                                                    : lwsp_pkg::LWSP_IDLE;
  assign wb_write = flow ? (s1_op_q == lwsp_pkg::LWSP_WRITE)
                         : (s2_op_q == lwsp_pkg::LWSP_WRITE);
  assign wb_addr = flow ? s1_addr_q : s2_addr_q;
  assign wb_lanes = flow ? s1_lanes_q : s2_lanes_q;
  assign drive = doe_q & ~output_enable_n & ~sleep_s2_q;

  assign lane_a_io_o = dout_q[0*LW +: LW];
  assign lane_b_io_o = dout_q[1*LW +: LW];
  assign lane_c_io_o = dout_q[2*LW +: LW];
  assign lane_d_io_o = dout_q[3*LW +: LW];
  assign lane_a_io_oe = {LW{drive}};
  assign lane_b_io_oe = {LW{drive}};
  assign lane_c_io_oe = {LW{drive}};
  assign lane_d_io_oe = {LW{drive}};
  assign sleep_active = sleep_s2_q;

  lwsp_burst u_burst (
    .ref_clk(ref_clk),
    .rst(rst),
    .step_en(active),
    .load(load),
    .linear_order_n(linear_order_n),
    .seed(burst_seed_addr),
    .low_addr(low_addr)
  );

  lwsp_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(read_go & ~flow),
    .in_ready(fifo_in_ready),
    .in_data(rd_data),
    .out_valid(fifo_out_valid),
    .out_ready(active & ~flow),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
    end else begin
      sleep_s1_q <= sleep_request;
      sleep_s2_q <= sleep_s1_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last_op_q <= lwsp_pkg::LWSP_IDLE;
      s1_op_q <= lwsp_pkg::LWSP_IDLE;
      s2_op_q <= lwsp_pkg::LWSP_IDLE;
      s1_addr_q <= '0;
      s2_addr_q <= '0;
      s1_lanes_q <= '0;
      s2_lanes_q <= '0;
    end else if (active) begin
      last_op_q <= op_now;
      s1_op_q <= wr_keep;
      s1_addr_q <= eff_addr;
      s1_lanes_q <= lanes_now;
      s2_op_q <= s1_op_q;
      s2_addr_q <= s1_addr_q;
      s2_lanes_q <= s1_lanes_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (active & wb_write) begin
      for (int i = 0; i < NL; i++) begin
        if (wb_lanes[i]) begin
          mem[wb_addr][i*LW +: LW] <= din[i*LW +: LW];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dout_q <= lwsp_pkg::DOUT_RST;
      doe_q <= 1'b0;
    end else if (active) begin
      if (flow) begin
        doe_q <= read_go;
        if (read_go) begin
          dout_q <= rd_data;
        end
      end else begin
        doe_q <= fifo_out_valid;
        if (fifo_out_valid) begin
          dout_q <= fifo_out_data;
        end
      end
    end
  end
endmodule

// *** tb/lwsp_top_properties.sv ***
// assertions on the sram port pins
// assumes one ref_clk domain and rst asynchronous, active high
`timescale 1ns/1ps
module lwsp_top_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // controls
  input wire logic advance_load,
  input wire logic write_select_n,
  input wire logic select_first_n,
  input wire logic select_second,
  input wire logic select_third_n,
  input wire logic clk_gate_n,
  input wire logic output_enable_n,
  input wire logic flow_mode_n,
  input wire logic sleep_request,
  // outputs
  input wire logic [8:0] lane_a_io_o,
  input wire logic [8:0] lane_a_io_oe,
  input wire logic sleep_active
);
  wire act = !clk_gate_n && !sleep_active;
  wire ld = act && !advance_load;
  wire sel = !select_first_n && select_second && !select_third_n;
  wire rd = ld && sel && write_select_n;
  wire wr = ld && sel && !write_select_n;
  wire ds = ld && !sel;
  wire off = lane_a_io_oe == 9'h000;
  wire hold = output_enable_n || sleep_active || lane_a_io_oe == 9'h1FF;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_oe_kill; output_enable_n |-> off; endproperty
  a_oe_kill: assert property (p_oe_kill)
    else $error("drivers on with output enable high");
  property p_pipe_late; ds && flow_mode_n ##1 rd && flow_mode_n |-> ##1 off;
  endproperty
  a_pipe_late: assert property (p_pipe_late)
    else $error("pipelined read data too early");
  property p_pipe_rd; rd && flow_mode_n ##1 act |-> ##1 hold; endproperty
  a_pipe_rd: assert property (p_pipe_rd)
    else $error("pipelined read data missing");
  property p_flow_rd; rd && !flow_mode_n |-> ##1 hold; endproperty
  a_flow_rd: assert property (p_flow_rd)
    else $error("flow read data missing");
  property p_wr_z; wr && flow_mode_n ##1 act |-> ##1 off; endproperty
  a_wr_z: assert property (p_wr_z)
    else $error("bus driven in write cycle");
  property p_desel; ds && flow_mode_n ##1 act |-> ##1 off; endproperty
  a_desel: assert property (p_desel)
    else $error("bus driven when deselected");
  property p_stall; clk_gate_n && !sleep_request ##1 $stable(output_enable_n)
    |-> $stable(lane_a_io_o) && $stable(lane_a_io_oe); endproperty
  a_stall: assert property (p_stall)
    else $error("outputs moved during stall");
  property p_sleep; $rose(sleep_request) |-> ##1 !sleep_active ##1 sleep_active;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep entry not two cycles");
endmodule
bind lwsp_top lwsp_top_properties chk_u (.*);

// *** tb/lwsp_host.sv ***
// memory controller model driving every input pin of the sram port but ref_clk and rst
// assumes one op call per clock cycle, made by the bench
`timescale 1ns/1ps
module lwsp_host (
  // clock
  input wire logic ref_clk,
  // address and control
  output logic [3:0] addr_hi,
  output logic [1:0] burst_seed_addr,
  output logic advance_load,
  output logic write_select_n,
  output logic select_first_n,
  output logic select_second,
  output logic select_third_n,
  output logic clk_gate_n,
  output logic output_enable_n,
  // strobes and modes
  output logic lane_a_strobe_n,
  output logic lane_b_strobe_n,
  output logic lane_c_strobe_n,
  output logic lane_d_strobe_n,
  output logic flow_mode_n,
  output logic linear_order_n,
  output logic sleep_request,
  // write data
  output logic [8:0] lane_a_io_i,
  output logic [8:0] lane_b_io_i,
  output logic [8:0] lane_c_io_i,
  output logic [8:0] lane_d_io_i
);
  logic [35:0] wd_q, wq [3], mem [logic [5:0]];
  logic [35:0] exp_q [$];
  logic [5:0] base;
  logic [2:0] wv;
  logic [1:0] k, nd;
  logic sel_q, wr_q;
  assign {lane_d_io_i, lane_c_io_i, lane_b_io_i, lane_a_io_i} = wd_q;
  initial begin
    {addr_hi, burst_seed_addr, advance_load, write_select_n} = '0;
    {select_first_n, select_second, select_third_n, clk_gate_n} = 4'hB;
    {output_enable_n, flow_mode_n, linear_order_n, sleep_request} = 4'hE;
    {lane_d_strobe_n, lane_c_strobe_n, lane_b_strobe_n} = 3'h7;
    lane_a_strobe_n = 1'b1;
    {wd_q, wv, k, nd, sel_q, wr_q, base} = '0;
  end
  task automatic op(input bit w, s, a, g, o, input logic [5:0] ad,
                    input logic [3:0] sb, input logic [35:0] wd);
    logic [5:0] x;
    logic [35:0] m;
    @(posedge ref_clk);
    if (!g) begin
      if (!a) {sel_q, wr_q, base, k} = {s, w, ad, 2'h0};
      else k = k + 2'h1;
      x = {base[5:2], linear_order_n ? base[1:0] ^ k : base[1:0] + k};
      m = mem.exists(x) ? mem[x] : 36'h000000000;
      for (int j = 0; j < 4; j++) if (!sb[j]) m[j*9+:9] = wd[j*9+:9];
      if (sel_q && wr_q) begin
        mem[x] = m;
        wq[flow_mode_n ? 2 : 1] = wd;
        wv[flow_mode_n ? 2 : 1] = 1'b1;
      end
      if (sel_q && !wr_q && !o) exp_q.push_back(mem[x]);
    end
    nd = (nd == 2'h2) ? 2'h0 : nd + 2'h1;
    advance_load <= a;
    write_select_n <= !w;
    {addr_hi, burst_seed_addr} <= ad;
    select_first_n <= !s && nd == 2'h0;
    select_second <= s || nd != 2'h1;
    select_third_n <= !s && nd == 2'h2;
    clk_gate_n <= g;
    output_enable_n <= o;
    {lane_d_strobe_n, lane_c_strobe_n, lane_b_strobe_n} <= sb[3:1];
    lane_a_strobe_n <= sb[0];
    wd_q <= wv[0] ? wq[0] : ~wd_q;
    if (!g) begin
      wq[0] = wq[1];
      wq[1] = wq[2];
      wv = wv >> 1;
    end
  endtask
  task automatic cfg(input bit f, l);
    @(posedge ref_clk);
    flow_mode_n <= f;
    linear_order_n <= l;
  endtask
  task automatic nap();
    @(posedge ref_clk);
    sleep_request <= 1'b1;
  endtask
endmodule

// *** tb/late_write_sync_sram_port_bench.sv ***
// testbench for the sram port, all modes, with a read monitor
// assumes lwsp_host drives every input pin but ref_clk and rst, and notes expected reads
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("FAIL %0t value mismatch", $time); end end
module late_write_sync_sram_port_bench;
  logic ref_clk, rst, gate_seen;
  int failures, tests_run;
  logic [31:0] lfsr_q = 32'h8507;
  logic [35:0] d, e;
  logic [1:0] sd;
  wire [3:0] addr_hi;
  wire [1:0] burst_seed_addr;
  wire advance_load, write_select_n, select_first_n, select_second;
  wire select_third_n, clk_gate_n, output_enable_n, sleep_request;
  wire lane_a_strobe_n, lane_b_strobe_n, lane_c_strobe_n, lane_d_strobe_n;
  wire flow_mode_n, linear_order_n, sleep_active;
  wire [8:0] lane_a_io_i, lane_b_io_i, lane_c_io_i, lane_d_io_i;
  wire [8:0] lane_a_io_o, lane_b_io_o, lane_c_io_o, lane_d_io_o;
  wire [8:0] lane_a_io_oe, lane_b_io_oe, lane_c_io_oe, lane_d_io_oe;
  lwsp_top #(.ADDR_W(6)) dut_u (.*);
  lwsp_host host_u (.*);
  function automatic logic [35:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return {lfsr_q[7:4], lfsr_q};
  endfunction
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // compare each fresh read word with the oldest note
  always @(posedge ref_clk) gate_seen <= clk_gate_n;
  always @(negedge ref_clk) begin
    if (!rst && !gate_seen && lane_a_io_oe[0] === 1'b1) begin
      e = host_u.exp_q.size() ? host_u.exp_q.pop_front() : 'x;
      `CHK({lane_d_io_o, lane_c_io_o, lane_b_io_o, lane_a_io_o}, e)
      `CHK(lane_d_io_oe & lane_c_io_oe & lane_b_io_oe, 9'h1FF)
    end
  end
  task automatic run_set();
    for (int i = 0; i < 8; i++) host_u.op(1, 1, 0, 0, 0, 6'(i), 4'h0, rnd());
    host_u.op(0, 0, 0, 0, 0, 6'h0, 4'hF, rnd());
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      host_u.op(1, 1, 0, 0, 0, 6'(i), d[35:32], d);
      host_u.op(0, 1, 0, 0, 0, 6'((i + 4) % 8), 4'hF, d);
    end
    sd = 2'(rnd());
    for (int k = 0; k < 4; k++) begin
      host_u.op(1, 1, k > 0, 0, 0, {4'h2, sd}, 4'h0, rnd());
    end
    host_u.op(0, 0, 0, 0, 0, 6'h0, 4'hF, d);
    for (int k = 0; k < 5; k++) begin
      host_u.op(0, 1, k > 0, 0, 0, {4'h2, sd}, 4'hF, d);
      if (k == 2) host_u.op(0, 1, 1, 1, 0, 6'h0, 4'hF, d);
    end
    repeat (2) host_u.op(0, 0, 0, 0, 0, 6'h0, 4'hF, d);
    host_u.op(0, 1, 0, 0, 1, 6'h1, 4'hF, d);
    repeat (4) host_u.op(0, 0, 0, 0, 1, 6'h0, 4'hF, d);
    `CHK(host_u.exp_q.size(), 0)
  endtask
  initial begin
    failures = 0;
    tests_run = 0;
    rst = 1'b1;
    for (int m = 0; m < 4; m++) begin
      rst <= 1'b1;
      host_u.cfg(m[0], m[1]);
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      run_set();
    end
    host_u.nap();
    repeat (2) @(negedge ref_clk);
    `CHK(sleep_active, 1'b0)
    @(negedge ref_clk);
    `CHK(sleep_active, 1'b1)
    close_out();
  end
  // about 200 cycles expected; cut off at 4000
  initial begin
    #100000;
    failures++;
    close_out();
  end
  task automatic close_out();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
endmodule
